// ### common/icr_pkg.sv
package icr_pkg;

	// ****************************************
	// Bus address and status byte layout
	// ****************************************
	localparam logic [4:0] DEF_ADDR = 5'h04;
	localparam int SB_SRQ_BIT = 6;
	localparam int SB_RDY_BIT = 4;

	// ****************************************
	// Preset limits and parser sizes
	// ****************************************
	localparam logic [6:0] BASE_MAX = 7'h63;
	localparam logic [6:0] EXP_MAX = 7'h06;
	localparam logic [6:0] NUM_SAT = 7'h7f;
	localparam int KW_BITS = 144;

	// ****************************************
	// Record lengths and fixed records
	// ****************************************
	localparam logic [4:0] REC_LEN = 5'h0b;
	localparam logic [4:0] CNT_LEN = 5'h13;
	localparam logic [87:0] DONE_STR = {"%000000069", 8'h0a};
	localparam logic [87:0] PWR_OK_STR = {"%001000070", 8'h0a};
	localparam logic [87:0] PWR_FAIL_STR = {"%001000071", 8'h0a};
	localparam logic [87:0] ERR_STR = {"%000000130", 8'h0a};

	// ****************************************
	// Characters
	// ****************************************
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_DASH = 8'h2d;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_US = 8'h5f;

	// ****************************************
	// Command keywords, right aligned
	// ****************************************
	localparam logic [143:0] KW_START = 144'("START");
	localparam logic [143:0] KW_STOP = 144'("STOP");
	localparam logic [143:0] KW_SET_PRE = 144'("SET_COUNT_PRESET");
	localparam logic [143:0] KW_CLR_PRE = 144'("CLEAR_COUNT_PRESET");
	localparam logic [143:0] KW_SHOW_CNT = 144'("SHOW_COUNTS");
	localparam logic [143:0] KW_SHOW_VER = 144'("SHOW_VERSION");

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_SELFTEST = 2'b00,
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} icr_st_t;

	typedef enum logic [2:0] {
		REC_DONE = 3'b000,
		REC_PWR_OK = 3'b001,
		REC_PWR_FAIL = 3'b010,
		REC_ERR = 3'b011,
		REC_VER = 3'b100,
		REC_CNT = 3'b101
	} icr_rec_t;

	typedef struct packed {
		icr_st_t st;
		logic [4:0] addr;
		logic srq;
		logic [7:0] sb;
		logic sbv;
		logic [143:0] kw;
		logic sep;
		logic par;
		logic nsel;
		logic [6:0] n0;
		logic [6:0] n1;
		logic bad;
		icr_rec_t rec;
		logic second;
		logic [4:0] idx;
		logic [7:0] txd;
		logic txv;
		logic txe;
		logic gate;
		logic [6:0] base;
		logic [2:0] expo;
		logic [63:0] snap;
	} icr_state_t;

endpackage : icr_pkg

// ### logic/icr_responder.sv
`timescale 1ns/1ps
// Operation
// [R1] Service request active whenever a record waits for the controller; the code drops it on a poll or on the first byte read.
// [R2] Serial poll or record read releases service request; poll returns status byte.
// [R3] Pending unread record blocks new commands; controller reads all records first.
// [R4] Idle and ready gives status byte with only bit 4 set.
// [R5] Power-up self-test outcome queued as power-up record.
// [R6] Power-up record read before commands; clean test gives %001000070.
// [R7] Poll with power-up record pending returns 64.
// [R8] Each successful command queues completion record %000000069.
// [R9] Query gives value record then completion record; both must be read.
// [R10] Address selectable 0 to 31; avoid 0 and 31.
// [R11] Address defaults to 4; addresses unique on the bus.
// [R12] Load preset sets base and exponent, count base times ten to exponent.
// [R13] Clear preset zeroes both preset fields.
// [R14] Start opens gate, lights gate indicator, counting begins.
// [R15] Stop closes gate, darkens indicator, counts hold.
// [R16] Counter query returns two eight-digit counters split by semicolon, then completion.
// [R17] Version query returns firmware revision record, then completion.
// [R18] Controller ends every transfer to the device with line feed.
// [R19] Service request is bit 6 of status byte, hex 40 alone.
// [R20] Most records are 11 bytes including line feed.
// [R21] Counter value record is 19 bytes including terminator.
// [R22] Preset base accepts 0 to 99, exponent 0 to 6.
// [R23] Keywords match ignoring case; hyphen and underscore are equivalent.
module icr_responder #(
	parameter logic [79:0] VERSION_ID = "$XX000-000" // Arbitrary value
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [4:0] addr_sw_in,
	input wire logic [4:0] bus_addr_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in,
	input wire logic tx_ready_in,
	input wire logic spoll_in,
	input wire logic selftest_done_in,
	input wire logic selftest_pass_in,
	input wire logic [31:0] count_a_bcd_in,
	input wire logic [31:0] count_b_bcd_in,
	output logic srq_out,
	output logic [7:0] spoll_data_out,
	output logic spoll_valid_out,
	output logic [7:0] tx_data_out,
	output logic tx_valid_out,
	output logic tx_end_out,
	output logic gate_out,
	output logic gate_led_out,
	output logic [6:0] two_digit_base_out,
	output logic [2:0] preset_exp_out,
	output logic [4:0] dev_addr_out
);

	// ****************************************
	// Record contents
	// ****************************************
	function automatic logic [4:0] rec_len(input icr_pkg::icr_rec_t r);
		rec_len = (r == icr_pkg::REC_CNT) ? icr_pkg::CNT_LEN : icr_pkg::REC_LEN; // [R20] [R21]
	endfunction : rec_len

	function automatic logic [7:0] rec_char(input icr_pkg::icr_rec_t r, input logic [4:0] i,
		input logic [63:0] snap);
		logic [87:0] s;
		int k;
		s = icr_pkg::DONE_STR; // [R8]
		k = int'(i);
		unique case (r)
			icr_pkg::REC_PWR_OK: s = icr_pkg::PWR_OK_STR; // [R6]
			icr_pkg::REC_PWR_FAIL: s = icr_pkg::PWR_FAIL_STR;
			icr_pkg::REC_ERR: s = icr_pkg::ERR_STR;
			icr_pkg::REC_VER: s = {VERSION_ID, icr_pkg::CH_LF}; // [R17]
			default: s = icr_pkg::DONE_STR;
		endcase
		if (r != icr_pkg::REC_CNT)
			rec_char = s[87 - 8 * k -: 8];
		else if (k < 8) // [R16]
			rec_char = icr_pkg::CH_ZERO + {4'h0, snap[63 - 4 * k -: 4]};
		else if (k == 8)
			rec_char = icr_pkg::CH_SEMI;
		else if (k < 17)
			rec_char = icr_pkg::CH_ZERO + {4'h0, snap[31 - 4 * (k - 9) -: 4]};
		else if (k == 17)
			rec_char = icr_pkg::CH_CR;
		else
			rec_char = icr_pkg::CH_LF;
	endfunction : rec_char

	// ****************************************
	// State
	// ****************************************
	icr_pkg::icr_state_t q;
	icr_pkg::icr_state_t d;
	logic rx_hit;
	logic tx_hit;
	logic sp_hit;
	logic ld;
	logic [7:0] uc;
	logic [6:0] cur;
	logic [10:0] nx;

	assign srq_out = q.srq;
	assign spoll_data_out = q.sb;
	assign spoll_valid_out = q.sbv;
	assign tx_data_out = q.txd;
	assign tx_valid_out = q.txv;
	assign tx_end_out = q.txe;
	assign gate_out = q.gate;
	assign gate_led_out = q.gate;
	assign two_digit_base_out = q.base;
	assign preset_exp_out = q.expo;
	assign dev_addr_out = q.addr;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		d = q;
		ld = 1'b0;
		rx_hit = rx_valid_in && (bus_addr_in == q.addr);
		tx_hit = q.txv && tx_ready_in && (bus_addr_in == q.addr);
		sp_hit = spoll_in && (bus_addr_in == q.addr);
		uc = rx_data_in;
		if (rx_data_in >= 8'h61 && rx_data_in <= 8'h7a) // [R23]
			uc = rx_data_in - 8'h20;
		cur = q.nsel ? q.n1 : q.n0;
		nx = {4'h0, cur} * 11'h00a + {7'h00, rx_data_in[3:0]};
		d.addr = addr_sw_in; // [R10] [R11]
		d.sbv = 1'b0;
		if (sp_hit)
		begin
			d.sb = 8'h00;
			d.sb[icr_pkg::SB_SRQ_BIT] = q.srq; // [R19] [R7]
			d.sb[icr_pkg::SB_RDY_BIT] = (q.st == icr_pkg::ST_IDLE); // [R4]
			d.sbv = 1'b1;
			d.srq = 1'b0; // [R2]
		end
		unique case (q.st)
			icr_pkg::ST_SELFTEST:
				if (selftest_done_in)
				begin
					d.rec = selftest_pass_in ? icr_pkg::REC_PWR_OK : icr_pkg::REC_PWR_FAIL; // [R5]
					d.second = 1'b0;
					ld = 1'b1;
				end
			icr_pkg::ST_IDLE:
				if (rx_hit)
				begin
					if (uc == icr_pkg::CH_DASH || uc == icr_pkg::CH_US || uc == icr_pkg::CH_SP)
					begin
						// Separators ahead of the keyword are dropped
						if (!q.par && q.kw != '0)
							d.sep = 1'b1; // [R23]
					end
					else if (uc >= 8'h41 && uc <= 8'h5a)
					begin
						// A pending separator needs a slot of its own
						if (q.par || q.kw[143 -: 8] != 8'h00
							|| (q.sep && q.kw[135 -: 8] != 8'h00))
							d.bad = 1'b1;
						else if (q.sep)
							d.kw = {q.kw[127:0], icr_pkg::CH_US, uc};
						else
							d.kw = {q.kw[135:0], uc};
						d.sep = 1'b0;
					end
					else if (uc >= icr_pkg::CH_ZERO && uc <= 8'h39)
					begin
						d.par = 1'b1;
						d.sep = 1'b0;
						if (q.nsel)
							d.n1 = (nx > 11'h07f) ? icr_pkg::NUM_SAT : nx[6:0];
						else
							d.n0 = (nx > 11'h07f) ? icr_pkg::NUM_SAT : nx[6:0];
					end
					else if (uc == icr_pkg::CH_COMMA)
					begin
						if (q.par && !q.nsel)
							d.nsel = 1'b1;
						else
							d.bad = 1'b1;
					end
					else if (uc == icr_pkg::CH_LF) // [R18]
					begin
						d.rec = icr_pkg::REC_DONE; // [R8]
						d.second = 1'b0;
						ld = 1'b1;
						if (q.bad)
							d.rec = icr_pkg::REC_ERR;
						else if (q.kw == icr_pkg::KW_START && !q.par)
							d.gate = 1'b1; // [R14]
						else if (q.kw == icr_pkg::KW_STOP && !q.par)
							d.gate = 1'b0; // [R15]
						else if (q.kw == icr_pkg::KW_SET_PRE && q.nsel
							&& q.n0 <= icr_pkg::BASE_MAX && q.n1 <= icr_pkg::EXP_MAX) // [R22]
						begin
							d.base = q.n0; // [R12]
							d.expo = q.n1[2:0];
						end
						else if (q.kw == icr_pkg::KW_CLR_PRE && !q.par)
						begin
							d.base = 7'h00; // [R13]
							d.expo = 3'h0;
						end
						else if (q.kw == icr_pkg::KW_SHOW_CNT && !q.par)
						begin
							d.snap = {count_a_bcd_in, count_b_bcd_in}; // [R16]
							d.rec = icr_pkg::REC_CNT;
							d.second = 1'b1; // [R9]
						end
						else if (q.kw == icr_pkg::KW_SHOW_VER && !q.par)
						begin
							d.rec = icr_pkg::REC_VER; // [R17]
							d.second = 1'b1; // [R9]
						end
						else
							d.rec = icr_pkg::REC_ERR;
						d.kw = '0;
						d.sep = 1'b0;
						d.par = 1'b0;
						d.nsel = 1'b0;
						d.n0 = 7'h00;
						d.n1 = 7'h00;
						d.bad = 1'b0;
					end
					else if (uc != icr_pkg::CH_CR)
						d.bad = 1'b1;
				end
			icr_pkg::ST_SEND:
				// Bytes arriving here are dropped: a record is still unread
				if (tx_hit) // [R3]
				begin
					d.srq = 1'b0; // [R2]
					if (q.txe)
					begin
						if (q.second)
						begin
							d.rec = icr_pkg::REC_DONE; // [R9]
							d.second = 1'b0;
							ld = 1'b1;
						end
						else
						begin
							d.st = icr_pkg::ST_IDLE;
							d.txv = 1'b0;
							d.txe = 1'b0;
						end
					end
					else
					begin
						d.idx = q.idx + 5'h01;
						d.txd = rec_char(q.rec, d.idx, q.snap);
						d.txe = (d.idx == rec_len(q.rec) - 5'h01); // [R20] [R21]
					end
				end
			default:
				d.st = icr_pkg::ST_IDLE;
		endcase
		// A newly queued record raises the request even against a same-cycle poll
		if (ld)
		begin
			d.st = icr_pkg::ST_SEND;
			d.idx = 5'h00;
			d.txd = rec_char(d.rec, 5'h00, d.snap);
			d.txv = 1'b1;
			d.txe = 1'b0;
			d.srq = 1'b1; // [R1]
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			q <= '0;
			q.addr <= icr_pkg::DEF_ADDR; // [R11]
		end
		else
			q <= d;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking dc @(posedge core_clk_in);
	endclocking
	default disable iff (!nrst_in);

	srq_on_queue_a: assert property (ld |=> srq_out && tx_valid_out) // [R1]
		else $error("request not raised for queued record");
	poll_release_a: assert property (sp_hit && !ld |=> !srq_out && spoll_valid_out) // [R2]
		else $error("poll did not release request");
	read_release_a: assert property (tx_hit && !q.txe |=> !srq_out) // [R2]
		else $error("read did not release request");
	busy_ignore_a: assert property (q.st == icr_pkg::ST_SEND && rx_hit // [R3]
		|=> $stable(q.kw) && $stable(gate_out) && $stable(two_digit_base_out))
		else $error("command taken while record pending");
	ready_byte_a: assert property (sp_hit && q.st == icr_pkg::ST_IDLE && !q.srq // [R4]
		|=> spoll_data_out == 8'h10)
		else $error("idle status byte wrong");
	pwr_code_a: assert property (q.st == icr_pkg::ST_SELFTEST && selftest_done_in // [R6]
		&& selftest_pass_in |=> q.rec == icr_pkg::REC_PWR_OK && tx_data_out == 8'h25)
		else $error("power-up record wrong");
	pwr_poll_a: assert property (sp_hit && q.srq && q.rec == icr_pkg::REC_PWR_OK // [R7]
		&& q.idx == 5'h00 |=> spoll_data_out == 8'h40)
		else $error("power-up poll byte not 64");
	srq_bit_a: assert property (sp_hit && q.srq // [R19]
		|=> spoll_valid_out && spoll_data_out[icr_pkg::SB_SRQ_BIT])
		else $error("request bit missing from status byte");
	pair_done_a: assert property (tx_hit && q.txe && q.second // [R9]
		|=> q.rec == icr_pkg::REC_DONE && srq_out && tx_data_out == 8'h25)
		else $error("completion record missing after value");
	rec_length_a: assert property (tx_hit && q.txe // [R20]
		|-> q.idx == rec_len(q.rec) - 5'h01 && tx_data_out == icr_pkg::CH_LF)
		else $error("record length wrong");
	count_semi_a: assert property (q.rec == icr_pkg::REC_CNT // [R16]
		&& q.st == icr_pkg::ST_SEND && q.idx == 5'h08 |-> tx_data_out == icr_pkg::CH_SEMI)
		else $error("counter record separator wrong");
	preset_range_a: assert property (two_digit_base_out <= icr_pkg::BASE_MAX // [R22]
		&& {4'h0, preset_exp_out} <= icr_pkg::EXP_MAX)
		else $error("preset out of range");
	preset_keep_a: assert property (q.st == icr_pkg::ST_IDLE && rx_hit // [R22]
		&& rx_data_in == icr_pkg::CH_LF && q.n1 > icr_pkg::EXP_MAX
		|=> $stable(two_digit_base_out) && $stable(preset_exp_out))
		else $error("out of range preset was loaded");
	preset_load_a: assert property (q.st == icr_pkg::ST_IDLE && rx_hit // [R12]
		&& rx_data_in == icr_pkg::CH_LF && !q.bad && q.kw == icr_pkg::KW_SET_PRE && q.nsel
		&& q.n0 <= icr_pkg::BASE_MAX && q.n1 <= icr_pkg::EXP_MAX
		|=> two_digit_base_out == $past(q.n0) && {4'h0, preset_exp_out} == $past(q.n1))
		else $error("preset not loaded");
	clear_preset_a: assert property (q.st == icr_pkg::ST_IDLE && rx_hit // [R13]
		&& rx_data_in == icr_pkg::CH_LF && !q.bad && q.kw == icr_pkg::KW_CLR_PRE && !q.par
		|=> two_digit_base_out == 7'h00 && preset_exp_out == 3'h0)
		else $error("preset not cleared");
	start_gate_a: assert property (q.st == icr_pkg::ST_IDLE && rx_hit // [R14]
		&& rx_data_in == icr_pkg::CH_LF && !q.bad && q.kw == icr_pkg::KW_START && !q.par
		|=> gate_out && gate_led_out)
		else $error("start did not open gate");
	stop_gate_a: assert property (q.st == icr_pkg::ST_IDLE && rx_hit // [R15]
		&& rx_data_in == icr_pkg::CH_LF && !q.bad && q.kw == icr_pkg::KW_STOP && !q.par
		|=> !gate_out && !gate_led_out)
		else $error("stop did not close gate");

	pwr_read_c: cover property (q.rec == icr_pkg::REC_PWR_OK && tx_hit && q.txe);
	fail_read_c: cover property (q.rec == icr_pkg::REC_PWR_FAIL && tx_hit && q.txe);
	show_cnt_c: cover property (q.rec == icr_pkg::REC_CNT && tx_hit && q.txe);
	preset_load_c: cover property (two_digit_base_out == 7'h19 && preset_exp_out == 3'h6);
	poll_idle_c: cover property (sp_hit && q.st == icr_pkg::ST_IDLE);

endmodule : icr_responder

// ### tb/icr_ctl_model.sv
`timescale 1ns/1ps
module icr_ctl_model (
	input wire logic clk_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	input wire logic tx_end_in,
	input wire logic [7:0] spoll_data_in,
	input wire logic spoll_valid_in,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic tx_ready_out,
	output logic spoll_out
);
	// ********
	// Bus controller actions
	// ********
	initial
	begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b0;
		spoll_out = 1'b0;
	end

	task automatic send(input string s);
		for (int i = 0; i <= s.len(); i++)
		begin
			@(negedge clk_in);
			rx_valid_out = 1'b1;
			rx_data_out = (i == s.len()) ? 8'h0a : s[i];
		end
		@(negedge clk_in);
		rx_valid_out = 1'b0;
		rx_data_out = ~rx_data_out;
	endtask : send

	// Takes one whole record; stall holds ready low first
	// Bytes are read at the falling edge, where they have settled; the next rising edge takes them
	task automatic fetch(input int stall, output logic [151:0] rec, output int n);
		logic last;
		last = 1'b0;
		rec = '0;
		n = 0;
		repeat (stall) @(negedge clk_in);
		@(negedge clk_in);
		tx_ready_out = 1'b1;
		for (int k = 0; k < 60 && !last; k++)
		begin
			if (tx_valid_in === 1'b1)
			begin
				rec = {rec[143:0], tx_data_in};
				n++;
				last = (tx_end_in === 1'b1);
			end
			@(negedge clk_in);
		end
		tx_ready_out = 1'b0;
	endtask : fetch

	task automatic poll(output logic [7:0] sb, output logic v);
		@(negedge clk_in);
		spoll_out = 1'b1;
		@(negedge clk_in);
		spoll_out = 1'b0;
		sb = spoll_data_in;
		v = spoll_valid_in;
	endtask : poll
endmodule : icr_ctl_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	localparam logic [79:0] VER_ID = "$AB123-456"; // Arbitrary value
	localparam logic [151:0] DONE = 152'({"%000000069", 8'h0a});
	logic clk, nrst, rx_valid, tx_ready, spoll, st_done, st_pass;
	logic [4:0] addr_sw, bus_addr, dev_addr;
	logic [7:0] rx_data, sb_data, tx_data;
	logic [31:0] cnt_a, cnt_b;
	logic srq, sb_valid, tx_valid, tx_end, gate, gate_led;
	logic [6:0] base;
	logic [2:0] expo;
	logic [151:0] r;
	logic [7:0] sb;
	logic v;
	int n;
	int failures = 0;
	int samples_checked = 0;

	icr_responder #(.VERSION_ID(VER_ID)) dut_u (.core_clk_in(clk), .nrst_in(nrst),
		.addr_sw_in(addr_sw), .bus_addr_in(bus_addr), .rx_data_in(rx_data),
		.rx_valid_in(rx_valid), .tx_ready_in(tx_ready), .spoll_in(spoll),
		.selftest_done_in(st_done), .selftest_pass_in(st_pass), .count_a_bcd_in(cnt_a),
		.count_b_bcd_in(cnt_b), .srq_out(srq), .spoll_data_out(sb_data),
		.spoll_valid_out(sb_valid), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
		.tx_end_out(tx_end), .gate_out(gate), .gate_led_out(gate_led),
		.two_digit_base_out(base), .preset_exp_out(expo), .dev_addr_out(dev_addr));

	icr_ctl_model ctl_u (.clk_in(clk), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
		.tx_end_in(tx_end), .spoll_data_in(sb_data), .spoll_valid_in(sb_valid),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid), .tx_ready_out(tx_ready),
		.spoll_out(spoll));

	// ********
	// Helpers
	// ********
	task automatic expect_rec(input logic [151:0] e, input int len, input int stall);
		ctl_u.fetch(stall, r, n);
		`CHK(r, e)
		`CHK(n, len)
	endtask : expect_rec

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// ********
	// Scenarios
	// ********
	task automatic t_powerup;
		st_pass = 1'b1;
		st_done = 1'b1;
		for (int k = 0; k < 50 && srq !== 1'b1; k++) @(negedge clk);
		`CHK(srq, 1'b1)
		ctl_u.poll(sb, v);
		`CHK(v, 1'b1)
		`CHK(sb, 8'h40)
		`CHK(srq, 1'b0)
		ctl_u.send("START");
		`CHK(gate, 1'b0)
		expect_rec(152'({"%001000070", 8'h0a}), 11, 3);
		`CHK(tx_valid, 1'b0)
		ctl_u.poll(sb, v);
		`CHK(sb, 8'h10)
		$display("test powerup done");
	endtask : t_powerup

	task automatic t_gate;
		ctl_u.send("start");
		`CHK({gate, gate_led}, 2'b11)
		`CHK(srq, 1'b1)
		expect_rec(DONE, 11, 2);
		`CHK(srq, 1'b0)
		ctl_u.send("Stop");
		`CHK({gate, gate_led}, 2'b00)
		expect_rec(DONE, 11, 0);
		$display("test gate done");
	endtask : t_gate

	task automatic t_preset;
		ctl_u.send("set-count-preset 25,6");
		`CHK({base, expo}, {7'h19, 3'h6})
		expect_rec(DONE, 11, 0);
		ctl_u.send("SET_COUNT_PRESET 99,7");
		`CHK({base, expo}, {7'h19, 3'h6})
		expect_rec(152'({"%000000130", 8'h0a}), 11, 0);
		ctl_u.send("Set_Count-Preset 99,0");
		`CHK({base, expo}, {7'h63, 3'h0})
		expect_rec(DONE, 11, 0);
		ctl_u.send("clear count preset");
		`CHK({base, expo}, {7'h00, 3'h0})
		expect_rec(DONE, 11, 0);
		$display("test preset done");
	endtask : t_preset

	task automatic t_query;
		ctl_u.send("SHOW_COUNTS");
		expect_rec({"12345678;00000000", 8'h0d, 8'h0a}, 19, 1);
		ctl_u.send("START");
		`CHK(gate, 1'b0)
		expect_rec(DONE, 11, 0);
		ctl_u.send("show_version");
		expect_rec(152'({VER_ID, 8'h0a}), 11, 0);
		expect_rec(DONE, 11, 4);
		$display("test query done");
	endtask : t_query

	task automatic t_addr;
		addr_sw = 5'h1e;
		repeat (2) @(negedge clk);
		`CHK(dev_addr, 5'h1e)
		ctl_u.poll(sb, v);
		`CHK(v, 1'b0)
		bus_addr = 5'h1e;
		ctl_u.poll(sb, v);
		`CHK({v, sb}, {1'b1, 8'h10})
		$display("test address done");
	endtask : t_addr

	task automatic t_selftest_fail;
		nrst = 1'b0;
		st_pass = 1'b0;
		repeat (2) @(negedge clk);
		`CHK({srq, gate, base, dev_addr}, {9'h000, 5'h04})
		nrst = 1'b1;
		@(negedge clk);
		`CHK({srq, tx_valid, dev_addr}, {2'b11, 5'h1e})
		ctl_u.poll(sb, v);
		`CHK({v, sb}, {1'b1, 8'h40})
		expect_rec(152'({"%001000071", 8'h0a}), 11, 0);
		$display("test selftest fail done");
	endtask : t_selftest_fail

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		#100us;
		failures++;
		report_and_stop();
	end

	initial
	begin
		nrst = 1'b0;
		addr_sw = 5'h04;
		bus_addr = 5'h04;
		st_done = 1'b0;
		st_pass = 1'b0;
		cnt_a = 32'h12345678;
		cnt_b = 32'h00000000;
		repeat (6) @(negedge clk);
		`CHK(dev_addr, 5'h04)
		`CHK(srq, 1'b0)
		nrst = 1'b1;
		t_powerup();
		t_gate();
		t_preset();
		t_query();
		t_addr();
		t_selftest_fail();
		report_and_stop();
	end
endmodule : tb_top
